// ==== shared/gec_pkg.sv ====
// Shared constants and types for the gated event counter group
package gec_pkg;
  // ==========================================================
  // Sizes
  localparam int NCNT = 10;
  localparam int CW = 24;
  localparam int AW = 8;
  localparam int DW = 32;
  localparam int NTB = 6;
  localparam int CFG_W = 11;
  // ==========================================================
  // Timebases
  localparam int CLK_HZ = 100_000_000;
  localparam int TB_20M_HZ = 20_000_000;
  localparam int TB_1M_HZ = 1_000_000;
  localparam int TB_100K_HZ = 100_000;
  localparam int TB_10K_HZ = 10_000;
  localparam int TB_1K_HZ = 1_000;
  localparam int TB_100_HZ = 100;
  localparam int DIV_20M = CLK_HZ / TB_20M_HZ;
  localparam int DIV_1M = CLK_HZ / TB_1M_HZ;
  localparam int DIV_100K = CLK_HZ / TB_100K_HZ;
  localparam int DIV_10K = CLK_HZ / TB_10K_HZ;
  localparam int DIV_1K = CLK_HZ / TB_1K_HZ;
  localparam int DIV_100 = CLK_HZ / TB_100_HZ;
  localparam logic [2:0] TB_NONE = 3'h7;
  // ==========================================================
  // Register map: addr[5:2] counter, addr[1:0] register
  localparam int ADDR_CNT_LSB = 2;
  localparam logic [1:0] REG_CFG = 2'h0;
  localparam logic [1:0] REG_CMD = 2'h1;
  localparam logic [1:0] REG_CNT = 2'h2;
  localparam logic [1:0] REG_LOAD = 2'h3;
  // Configuration fields
  localparam int CFG_CAS = 0;
  localparam int CFG_SEL = 1;
  localparam int CFG_HALT = 4;
  localparam int CFG_FALL = 5;
  localparam int CFG_GATE = 6;
  localparam int CFG_PULSE = 9;
  localparam int CFG_GPREV = 10;
  // Command and status bits
  localparam int CMD_START = 0;
  localparam int CMD_STOP = 1;
  localparam int STAT_OVF = 0;
  localparam int STAT_RUN = 1;
  localparam int STAT_OUT = 2;
  localparam int STAT_ARMED = 3;
  // Reset values and limits
  localparam logic [CFG_W-1:0] CFG_RST = 11'h000;
  localparam logic [CW-1:0] LOAD_RST = 24'h000001;
  localparam logic [CW-1:0] MAX16 = 24'h00FFFF;
  localparam logic [CW-1:0] MAX24 = 24'hFFFFFF;
  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    GATE_FREE = 3'h0,
    GATE_HIGH = 3'h1,
    GATE_LOW = 3'h2,
    GATE_RISE = 3'h3,
    GATE_FALL = 3'h4
  } gec_gate_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_ARMED = 2'h1,
    ST_RUN = 2'h3,
    ST_HALT = 2'h2
  } gec_st_t;
endpackage : gec_pkg

// ==== rtl/gec_tbdiv.sv ====
// Internal timebase divider giving rise and fall enable pulses
`timescale 1ns/1ps
module gec_tbdiv #(
  parameter int DIV = 5
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Timebase edges
  output logic rise_o,
  output logic fall_o
);
  logic [23:0] cnt_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= 24'h000000;
      rise_o <= 1'b0;
      fall_o <= 1'b0;
    end else begin
      cnt_reg <= (cnt_reg == 24'(DIV - 1)) ? 24'h000000 : cnt_reg + 24'h000001;
      rise_o <= (cnt_reg == 24'h000000);
      fall_o <= (cnt_reg == 24'(DIV / 2));
    end
  end
endmodule : gec_tbdiv

// ==== rtl/gec_top.sv ====
// Gated event and time counter group with register port
//
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/1ps
module gec_top #(
  parameter bit WIDE = 1'b0,
  parameter int DIV_10K = gec_pkg::DIV_10K,
  parameter int DIV_1K = gec_pkg::DIV_1K,
  parameter int DIV_100 = gec_pkg::DIV_100
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register port
  input wire logic [gec_pkg::AW-1:0] addr_i,
  input wire logic [gec_pkg::DW-1:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  output logic [gec_pkg::DW-1:0] rdata_o,
  // Counter pins
  input wire logic [gec_pkg::NCNT-1:0] src_i,
  input wire logic [gec_pkg::NCNT-1:0] gate_i,
  output logic [gec_pkg::NCNT-1:0] out_o
);
  // ==========================================================
  // Neighbour and decode functions
  function automatic logic [3:0] nxt(input logic [3:0] i);
    if (WIDE) begin
      nxt = i ^ 4'h1;
    end else if (i == 4'h4) begin
      nxt = 4'h0;
    end else if (i == 4'h9) begin
      nxt = 4'h5;
    end else begin
      nxt = i + 4'h1;
    end
  endfunction : nxt

  function automatic logic [3:0] prv(input logic [3:0] i);
    if (WIDE) begin
      prv = i ^ 4'h1;
    end else if (i == 4'h0) begin
      prv = 4'h4;
    end else if (i == 4'h5) begin
      prv = 4'h9;
    end else begin
      prv = i - 4'h1;
    end
  endfunction : prv

  function automatic logic [2:0] tbi(input logic [2:0] s);
    if (WIDE) begin
      if (s == 3'h1) begin
        tbi = 3'h0;
      end else if (s == 3'h2) begin
        tbi = 3'h2;
      end else begin
        tbi = gec_pkg::TB_NONE;
      end
    end else if (s != 3'h0 && s <= 3'h5) begin
      tbi = s;
    end else begin
      tbi = gec_pkg::TB_NONE;
    end
  endfunction : tbi

  function automatic logic [3:0] sel_cnt(input logic [gec_pkg::AW-1:0] a);
    sel_cnt = a[gec_pkg::ADDR_CNT_LSB +: 4];
  endfunction : sel_cnt

  // ==========================================================
  // Shared state
  localparam int DIVS [gec_pkg::NTB] = '{gec_pkg::DIV_20M, gec_pkg::DIV_1M,
    gec_pkg::DIV_100K, DIV_10K, DIV_1K, DIV_100};
  localparam int NC = gec_pkg::NCNT;
  localparam int CW = gec_pkg::CW;

  logic [gec_pkg::NTB-1:0] tb_rise;
  logic [gec_pkg::NTB-1:0] tb_fall;
  logic [CW-1:0] cnt_reg [NC];
  logic [CW-1:0] load_reg [NC];
  logic [gec_pkg::CFG_W-1:0] cfg_reg [NC];
  gec_pkg::gec_st_t st_reg [NC];
  logic [NC-1:0] ovf_reg;
  logic [NC-1:0] tick;
  logic [NC-1:0] at_max;
  logic [NC-1:0] tc_stop;
  logic [NC-1:0] cas;
  logic [NC-1:0] start_w;
  logic [NC-1:0] stop_w;
  logic [CW-1:0] max_v;
  logic [3:0] wsel;
  logic [1:0] wreg;
  logic [gec_pkg::DW-1:0] rd_mux;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  assign max_v = WIDE ? gec_pkg::MAX24 : gec_pkg::MAX16;
  assign wsel = sel_cnt(addr_i);
  assign wreg = addr_i[1:0];

  // ==========================================================
  // Timebases
  for (genvar t = 0; t < gec_pkg::NTB; t++) begin : g_tb
    gec_tbdiv #(.DIV(DIVS[t])) u_div (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .rise_o(tb_rise[t]),
      .fall_o(tb_fall[t])
    );
  end

  // ==========================================================
  // Counters
  for (genvar g = 0; g < NC; g++) begin : g_cnt
    localparam logic [3:0] NX = nxt(4'(g));
    localparam logic [3:0] PV = prv(4'(g));
    logic [2:0] sy_src;
    logic [2:0] sy_gate;
    logic src_lvl;
    logic src_prv;
    logic gpin_lvl;
    logic g_lvl;
    logic g_prv;
    logic [2:0] sel;
    logic [2:0] ti;
    logic [2:0] gm;
    logic fall;
    logic halt;
    logic pulse;
    logic hi;
    logic ev;
    logic gate_ok;
    logic gedge;
    logic clr;
    logic inc;
    logic stp;
    logic term;
    logic done;
    gec_pkg::gec_st_t st_next;

    assign sel = cfg_reg[g][gec_pkg::CFG_SEL +: 3];
    assign gm = cfg_reg[g][gec_pkg::CFG_GATE +: 3];
    assign fall = cfg_reg[g][gec_pkg::CFG_FALL];
    assign halt = cfg_reg[g][gec_pkg::CFG_HALT] & ~WIDE;
    assign pulse = cfg_reg[g][gec_pkg::CFG_PULSE];
    assign cas[g] = cfg_reg[g][gec_pkg::CFG_CAS] & ~WIDE;
    assign hi = cas[PV];
    assign ti = tbi(sel);

    // Gate may come from counter PV's pulse output: the preceding counter, or the pair partner (g ^ 1) when WIDE
    assign g_lvl = cfg_reg[g][gec_pkg::CFG_GPREV] ? out_o[PV] : gpin_lvl;
    assign gedge = (gm == gec_pkg::GATE_RISE) ? (g_lvl & ~g_prv) :
                   (gm == gec_pkg::GATE_FALL) ? (~g_lvl & g_prv) : 1'b0;
    assign gate_ok = (gm == gec_pkg::GATE_HIGH) ? g_lvl :
                     (gm == gec_pkg::GATE_LOW) ? ~g_lvl : 1'b1;

    always_comb begin
      if (sel == 3'h0) begin
        ev = fall ? (~src_lvl & src_prv) : (src_lvl & ~src_prv);
      end else if (ti == gec_pkg::TB_NONE) begin
        ev = 1'b0;
      end else begin
        ev = fall ? tb_fall[ti] : tb_rise[ti];
      end
    end

    assign tick[g] = (st_reg[g] == gec_pkg::ST_RUN) && gate_ok && ev;
    assign at_max[g] = (cnt_reg[g] == max_v);
    assign term = cas[g] ? (at_max[g] && at_max[NX]) : at_max[g];
    assign tc_stop[g] = tick[g] && halt && !pulse && term;
    assign done = tick[g] && pulse && (cnt_reg[g] <= 24'h000001);
    assign inc = hi ? (tick[PV] && at_max[PV] && !tc_stop[PV]) : tick[g];
    assign clr = start_w[g] || (hi && start_w[PV]);
    assign stp = hi ? stop_w[PV] : stop_w[g];

    assign start_w[g] = we_i && (wreg == gec_pkg::REG_CMD) && (wsel == 4'(g)) &&
                        wdata_i[gec_pkg::CMD_START] && !wdata_i[gec_pkg::CMD_STOP];
    assign stop_w[g] = we_i && (wreg == gec_pkg::REG_CMD) && (wsel == 4'(g)) &&
                       wdata_i[gec_pkg::CMD_STOP];

    always_comb begin
      st_next = st_reg[g];
      if (stop_w[g]) begin
        st_next = gec_pkg::ST_IDLE;
      end else if (start_w[g]) begin
        if (gm == gec_pkg::GATE_RISE || gm == gec_pkg::GATE_FALL) begin
          st_next = gec_pkg::ST_ARMED;
        end else begin
          st_next = gec_pkg::ST_RUN;
        end
      end else begin
        unique case (st_reg[g])
          gec_pkg::ST_ARMED: begin
            if (gedge) begin
              st_next = gec_pkg::ST_RUN;
            end
          end
          gec_pkg::ST_RUN: begin
            if (tc_stop[g] || done) begin
              st_next = gec_pkg::ST_HALT;
            end
          end
          gec_pkg::ST_IDLE, gec_pkg::ST_HALT: begin
            st_next = st_reg[g];
          end
        endcase
      end
    end

    // Pin synchronisers: a level counts once stages two and three agree
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        sy_src <= 3'h0;
        sy_gate <= 3'h0;
        src_lvl <= 1'b0;
        src_prv <= 1'b0;
        gpin_lvl <= 1'b0;
        g_prv <= 1'b0;
      end else begin
        sy_src <= {sy_src[1:0], src_i[g]};
        sy_gate <= {sy_gate[1:0], gate_i[g]};
        if (sy_src[1] == sy_src[2]) begin
          src_lvl <= sy_src[2];
        end
        if (sy_gate[1] == sy_gate[2]) begin
          gpin_lvl <= sy_gate[2];
        end
        src_prv <= src_lvl;
        g_prv <= g_lvl;
      end
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        cfg_reg[g] <= gec_pkg::CFG_RST;
        load_reg[g] <= gec_pkg::LOAD_RST;
      end else if (we_i && wsel == 4'(g)) begin
        if (wreg == gec_pkg::REG_CFG) begin
          cfg_reg[g] <= wdata_i[gec_pkg::CFG_W-1:0];
        end
        if (wreg == gec_pkg::REG_LOAD) begin
          load_reg[g] <= wdata_i[CW-1:0];
        end
      end
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        st_reg[g] <= gec_pkg::ST_IDLE;
      end else begin
        st_reg[g] <= st_next;
      end
    end

    // Single gate pulse: high from run start until the load runs out
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        out_o[g] <= 1'b0;
      end else begin
        out_o[g] <= pulse && (st_next == gec_pkg::ST_RUN);
      end
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        cnt_reg[g] <= 24'h000000;
      end else if (clr) begin
        cnt_reg[g] <= (pulse && !hi) ? load_reg[g] : 24'h000000;
      end else if (inc && !stp) begin
        if (pulse && !hi) begin
          cnt_reg[g] <= done ? 24'h000000 : cnt_reg[g] - 24'h000001;
        end else if (!tc_stop[g]) begin
          cnt_reg[g] <= at_max[g] ? 24'h000000 : cnt_reg[g] + 24'h000001;
        end
      end
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        ovf_reg[g] <= 1'b0;
      end else if (clr) begin
        ovf_reg[g] <= 1'b0;
      end else if (!stp && (tc_stop[g] || (WIDE && inc && at_max[g] && !pulse))) begin
        ovf_reg[g] <= 1'b1;
      end
    end

    // Assertions
    sequence stop_seq;
      stop_w[g] && !hi;
    endsequence
    sequence low_wrap_seq;
      hi && tick[PV] && at_max[PV] && !tc_stop[PV] && !stop_w[PV] && !clr;
    endsequence

    free_start_a: assert property (
      (start_w[g] && gm == gec_pkg::GATE_FREE) |=> st_reg[g] == gec_pkg::ST_RUN)
      else $error("free-run start did not enter run");
    high_gate_a: assert property (
      (st_reg[g] == gec_pkg::ST_RUN && gm == gec_pkg::GATE_HIGH && !g_lvl && !hi &&
       !start_w[g]) |=> $stable(cnt_reg[g]))
      else $error("counted while gate low in high-gated mode");
    low_gate_a: assert property (
      (st_reg[g] == gec_pkg::ST_RUN && gm == gec_pkg::GATE_LOW && g_lvl && !hi &&
       !start_w[g]) |=> $stable(cnt_reg[g]))
      else $error("counted while gate high in low-gated mode");
    armed_wait_a: assert property (
      (st_reg[g] == gec_pkg::ST_ARMED && !gedge && !start_w[g] && !stop_w[g] && !hi)
      |=> (st_reg[g] == gec_pkg::ST_ARMED && $stable(cnt_reg[g])))
      else $error("armed counter moved without gate edge");
    halt_terminal_a: assert property (
      (tc_stop[g] && !hi && !stop_w[g] && !start_w[g]) |=>
      (st_reg[g] == gec_pkg::ST_HALT && ovf_reg[g] && $stable(cnt_reg[g])))
      else $error("terminal count did not halt with overflow");
    narrow_wrap_a: assert property (
      (!WIDE && tick[g] && !halt && !pulse && !hi && at_max[g] && !stop_w[g] &&
       !start_w[g]) |=> (cnt_reg[g] == 24'h000000 && $stable(ovf_reg[g])))
      else $error("continuous narrow counter did not wrap cleanly");
    cascade_carry_a: assert property (
      low_wrap_seq |=> cnt_reg[g] ==
      ($past(at_max[g]) ? 24'h000000 : $past(cnt_reg[g]) + 24'h000001))
      else $error("high half missed carry");
    stop_hold_a: assert property (
      stop_seq ##1 !start_w[g] |-> (st_reg[g] == gec_pkg::ST_IDLE && $stable(cnt_reg[g])))
      else $error("counter moved after stop");
    count_read_a: assert property (
      (re_i && sel_cnt(addr_i) == 4'(g) && addr_i[1:0] == gec_pkg::REG_CNT && !cas[g])
      |=> rdata_o == {8'h00, $past(cnt_reg[g])})
      else $error("count read returned wrong value");
  end

  // ==========================================================
  // Read port
  always_comb begin
    logic [3:0] rs;
    rs = sel_cnt(addr_i);
    rd_mux = 32'h00000000;
    if (rs < 4'(NC)) begin
      unique case (addr_i[1:0])
        gec_pkg::REG_CFG: rd_mux = {21'h000000, cfg_reg[rs]};
        gec_pkg::REG_CMD: begin
          rd_mux[gec_pkg::STAT_OVF] = ovf_reg[rs];
          rd_mux[gec_pkg::STAT_RUN] = (st_reg[rs] == gec_pkg::ST_RUN);
          rd_mux[gec_pkg::STAT_OUT] = out_o[rs];
          rd_mux[gec_pkg::STAT_ARMED] = (st_reg[rs] == gec_pkg::ST_ARMED);
        end
        gec_pkg::REG_CNT: begin
          if (cas[rs]) begin
            rd_mux = {cnt_reg[nxt(rs)][15:0], cnt_reg[rs][15:0]};
          end else begin
            rd_mux = {8'h00, cnt_reg[rs]};
          end
        end
        gec_pkg::REG_LOAD: rd_mux = {8'h00, load_reg[rs]};
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= 32'h00000000;
    end else if (re_i) begin
      rdata_o <= rd_mux;
    end else begin
      rdata_o <= 32'h00000000;
    end
  end
endmodule : gec_top

// ==== test/gec_sig_model.sv ====
// Model of the external signal sources and pin wiring around the counters
`timescale 1ns/1ps
module gec_sig_model #(
  parameter int HALF = 5
) (
  // Clock
  input wire logic clk_i,
  // Counter outputs seen on the board
  input wire logic [gec_pkg::NCNT-1:0] out_i,
  // Driven pins
  output logic [gec_pkg::NCNT-1:0] src_o,
  output logic [gec_pkg::NCNT-1:0] gate_o
);
  logic [gec_pkg::NCNT-1:0] src_reg = 10'h000;
  logic [gec_pkg::NCNT-1:0] gate_reg = 10'h000;
  logic [gec_pkg::NCNT-1:0] link_en = 10'h000;
  logic [gec_pkg::NCNT-1:0] run_en = 10'h000;
  int ph = 0;
  // ==========================================
  // Wiring and free-running sources
  function automatic int prev_idx(input int i);
    return (i % 5 == 0) ? i + 4 : i - 1;
  endfunction : prev_idx
  always_comb begin
    for (int i = 0; i < gec_pkg::NCNT; i++) begin
      gate_o[i] = link_en[i] ? out_i[prev_idx(i)] : gate_reg[i];
    end
  end
  assign src_o = src_reg;
  always @(posedge clk_i) begin
    ph <= (ph == HALF - 1) ? 0 : ph + 1;
    for (int i = 0; i < gec_pkg::NCNT; i++) begin
      if (ph == HALF - 1 && run_en[i]) begin
        src_reg[i] <= ~src_reg[i];
      end
    end
  end
  // ==========================================
  // Pin tasks
  task automatic set_gate(input int i, input logic v);
    @(posedge clk_i);
    gate_reg[i] <= v;
  endtask : set_gate
  task automatic set_src(input int i, input logic v);
    @(posedge clk_i);
    src_reg[i] <= v;
  endtask : set_src
  task automatic set_link(input int i, input logic v);
    @(posedge clk_i);
    link_en[i] <= v;
  endtask : set_link
  task automatic set_run(input int i, input logic v);
    @(posedge clk_i);
    run_en[i] <= v;
  endtask : set_run
  task automatic pulses(input int i, input int n);
    repeat (n) begin
      @(posedge clk_i);
      src_reg[i] <= 1'b1;
      repeat (4) @(posedge clk_i);
      src_reg[i] <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
  endtask : pulses
endmodule : gec_sig_model

// ==== test/gec_top_tb.sv ====
// Self-checking bench for the gated event counter group
`timescale 1ns/1ps
module gec_top_tb;
  localparam int P_10K = 1;
  localparam int GATE_TICKS = 100;
  localparam logic [1:0] R_CFG = gec_pkg::REG_CFG;
  localparam logic [1:0] R_CMD = gec_pkg::REG_CMD;
  localparam logic [1:0] R_CNT = gec_pkg::REG_CNT;
  localparam logic [1:0] R_LD = gec_pkg::REG_LOAD;
  localparam logic [31:0] GO = 32'h1 << gec_pkg::CMD_START;
  localparam logic [31:0] STP = 32'h1 << gec_pkg::CMD_STOP;
  localparam logic [31:0] TB10K = 32'h3 << gec_pkg::CFG_SEL;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic we_i = 1'b0;
  logic re_i = 1'b0;
  logic [31:0] rdata_o;
  logic [9:0] src_i;
  logic [9:0] gate_i;
  logic [9:0] out_o;
  logic [31:0] v;
  int err_count = 0;
  int checks = 0;
  gec_top #(.WIDE(1'b0), .DIV_10K(P_10K), .DIV_1K(20), .DIV_100(40)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i),
    .re_i(re_i), .rdata_o(rdata_o), .src_i(src_i), .gate_i(gate_i), .out_o(out_o));
  gec_sig_model #(.HALF(5)) sig (.clk_i(clk_i), .out_i(out_o), .src_o(src_i), .gate_o(gate_i));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  // ==========================================
  // Bus and check helpers
  task automatic wr(input int c, input logic [1:0] r, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= {2'h0, 4'(c), r};
    wdata_i <= d;
    we_i <= 1'b1;
    @(posedge clk_i);
    we_i <= 1'b0;
  endtask : wr
  task automatic rd(input int c, input logic [1:0] r, output logic [31:0] d);
    @(posedge clk_i);
    addr_i <= {2'h0, 4'(c), r};
    re_i <= 1'b1;
    @(posedge clk_i);
    re_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask : rd
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic chk_rng(input string n, input logic [31:0] lo, hi, g);
    checks++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      err_count++;
      $display("CHECK FAILED %s expected %h..%h seen %h", n, lo, hi, g);
    end
  endtask : chk_rng
  task automatic rdc(input int c, input logic [1:0] r, input logic [31:0] e, input string n);
    rd(c, r, v);
    chk(n, e, v);
  endtask : rdc
  // Set gate of counter 0, send n source pulses, compare count
  task automatic gp(input logic g, input int n, input logic [31:0] e, input string nm);
    sig.set_gate(0, g);
    repeat (6) @(posedge clk_i);
    sig.pulses(0, n);
    repeat (8) @(posedge clk_i);
    rdc(0, R_CNT, e, nm);
  endtask : gp
  // ==========================================
  // Scenarios
  task automatic t_regs;
    rdc(0, R_CFG, 32'h0, "cfg reset");
    rdc(0, R_LD, 32'h1, "load reset");
    rdc(0, R_CMD, 32'h0, "status reset");
    wr(7, R_LD, 32'h00123456);
    rdc(7, R_LD, 32'h00123456, "load rw");
    wr(12, R_LD, 32'h00000055);
    rdc(12, R_LD, 32'h0, "unmapped");
  endtask : t_regs
  task automatic t_free;
    sig.set_gate(0, 1'b0);
    wr(0, R_CFG, 32'h0);
    wr(0, R_CMD, GO);
    gp(1'b0, 4, 32'h4, "free low gate");
    gp(1'b1, 2, 32'h6, "free high gate");
  endtask : t_free
  task automatic t_pol;
    for (int f = 0; f < 2; f++) begin
      wr(0, R_CFG, 32'(f) << gec_pkg::CFG_FALL);
      wr(0, R_CMD, GO);
      sig.set_src(0, 1'b1);
      repeat (10) @(posedge clk_i);
      rdc(0, R_CNT, 32'(1 - f), "after rise");
      sig.set_src(0, 1'b0);
      repeat (10) @(posedge clk_i);
      rdc(0, R_CNT, 32'h1, "after fall");
    end
  endtask : t_pol
  task automatic t_level;
    logic act;
    for (int m = 1; m < 3; m++) begin
      act = (m == 1);
      sig.set_gate(0, !act);
      wr(0, R_CFG, 32'(m) << gec_pkg::CFG_GATE);
      wr(0, R_CMD, GO);
      gp(!act, 3, 32'h0, "gate inactive");
      gp(act, 3, 32'h3, "gate active");
      gp(!act, 2, 32'h3, "held count");
      gp(act, 2, 32'h5, "resumed count");
    end
  endtask : t_level
  task automatic t_edge;
    logic idl;
    for (int m = 3; m < 5; m++) begin
      idl = (m == 4);
      sig.set_gate(0, idl);
      repeat (6) @(posedge clk_i);
      wr(0, R_CFG, 32'(m) << gec_pkg::CFG_GATE);
      wr(0, R_CMD, GO);
      rd(0, R_CMD, v);
      chk("armed", 32'h1, 32'(v[gec_pkg::STAT_ARMED]));
      gp(idl, 3, 32'h0, "before trigger");
      gp(!idl, 3, 32'h3, "after trigger");
    end
  endtask : t_edge
  task automatic t_timebase;
    int n[6];
    logic [31:0] w;
    n = '{2000 / gec_pkg::DIV_1M, 2000 / gec_pkg::DIV_100K, 2000 / P_10K, 100, 50, 0};
    for (int k = 1; k < 7; k++) begin
      wr(0, R_CFG, 32'(k) << gec_pkg::CFG_SEL);
      wr(0, R_CMD, GO);
      repeat (995) @(posedge clk_i);
      rd(0, R_CNT, w);
      repeat (1002) @(posedge clk_i);
      wr(0, R_CMD, STP);
      rd(0, R_CNT, w);
      chk_rng("timebase count", (n[k-1] > 0) ? n[k-1] - 1 : 0,
              (k == 6) ? 0 : n[k-1] + 2, w);
      repeat (100) @(posedge clk_i);
      rdc(0, R_CNT, w, "count after stop");
    end
  endtask : t_timebase
  task automatic t_freq(input int ev, input int gt, input logic gpv);
    logic [31:0] w;
    logic tmo;
    logic vld;
    sig.set_gate(ev, 1'b0);
    sig.set_link(ev, !gpv);
    sig.set_run(ev, 1'b1);
    wr(ev, R_CFG, (32'h1 << gec_pkg::CFG_GATE) | (32'(gpv) << gec_pkg::CFG_GPREV));
    wr(gt, R_CFG, TB10K | (32'h1 << gec_pkg::CFG_PULSE));
    wr(gt, R_LD, 32'(GATE_TICKS));
    wr(ev, R_CMD, GO);
    wr(gt, R_CMD, GO);
    tmo = 1'b1;
    for (int i = 0; i < 20 && tmo; i++) begin
      #1;
      if (out_o[gt] === 1'b1) tmo = 1'b0;
      @(posedge clk_i);
    end
    repeat (100) @(posedge clk_i);
    for (int i = 0; i < 50; i++) begin
      rd(gt, R_CMD, v);
      if (v[gec_pkg::STAT_OUT] === 1'b0) break;
    end
    chk("gate ended", 32'h0, 32'(v[gec_pkg::STAT_OUT]));
    rd(ev, R_CNT, w);
    rd(ev, R_CMD, v);
    vld = (v[gec_pkg::STAT_OVF] === 1'b0);
    wr(ev, R_CMD, STP);
    wr(gt, R_CMD, STP);
    chk_rng("frequency", 32'h00895440, 32'h00A7D8C0,
            w * (gec_pkg::CLK_HZ / (GATE_TICKS * P_10K)));
    chk("valid", 32'h1, 32'(vld));
    chk("timeout", 32'h0, 32'(tmo));
    sig.set_run(ev, 1'b0);
    sig.set_link(ev, 1'b0);
  endtask : t_freq
  task automatic t_terminal;
    int cs[4];
    cs = '{0, 1, 2, 9};
    wr(0, R_CFG, TB10K | (32'h1 << gec_pkg::CFG_HALT));
    wr(1, R_CFG, TB10K);
    wr(2, R_CFG, TB10K | 32'h1);
    wr(9, R_CFG, TB10K | 32'h1);
    foreach (cs[i]) wr(cs[i], R_CMD, GO);
    repeat (66000) @(posedge clk_i);
    rdc(0, R_CNT, 32'h0000FFFF, "halt count");
    rd(0, R_CMD, v);
    chk("halt status", 32'h1, v & 32'h3);
    rd(1, R_CNT, v);
    chk_rng("wrapped count", 32'h100, 32'h3FF, v);
    rd(1, R_CMD, v);
    chk("no overflow", 32'h0, 32'(v[gec_pkg::STAT_OVF]));
    rd(2, R_CNT, v);
    chk("cascade high", 32'h1, 32'(v[31:16]));
    rd(9, R_CNT, v);
    chk("ring cascade high", 32'h1, 32'(v[31:16]));
    foreach (cs[i]) wr(cs[i], R_CMD, STP);
  endtask : t_terminal
  // ==========================================
  // Sequence, watchdog and verdict
  task automatic stop_test;
    $display("Checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_free;
    t_pol;
    t_level;
    t_edge;
    t_timebase;
    t_freq(0, 4, 1'b1);
    t_freq(3, 2, 1'b0);
    t_terminal;
    stop_test;
  end
  initial begin
    repeat (95000) @(posedge clk_i);
    err_count++;
    $display("CHECK FAILED watchdog expected finish seen timeout");
    stop_test;
  end
endmodule : gec_top_tb
